// ---- rtl/lcrg_map.svh ----
/*
  constant map of the lane configuration register group: offsets, field
  positions, reset values, codes and timing figures.
  assumes the includer wants plain `define macros and nothing else.
*/
// Contract
// - idle bit 5 picks manual or automatic idle
// - manual mode: bit 4 mutes or enables output
// - detect code 00 high-z, 11 fixed 50 ohm
// - code 01: probe every 12 ms, 50 tries
// - code 10: probe every 12 ms until found
// - register detect mode beats the detect pin
// - equalizer byte, 256 levels, resets to 0x2f
// - swing bit 7 controls short-circuit protection
// - swing bit 6: 1 gen1/2, 0 gen3 mode
// - swing bits 2:0 pick 0.7 to 1.4 volt
// - read-only status bit shows receiver detected
`ifndef LCRG_MAP_SVH
`define LCRG_MAP_SVH

// ==========================================================
// register offsets
`define LCRG_ADDR_IDLE      8'h40
`define LCRG_ADDR_EQ        8'h41
`define LCRG_ADDR_SWING     8'h42
`define LCRG_ADDR_STATUS    8'h43

// ==========================================================
// reset values
`define LCRG_RST_IDLE       8'h00
`define LCRG_RST_EQ         8'h2f
`define LCRG_RST_SWING      8'had

// ==========================================================
// field positions
`define LCRG_IDLE_MANUAL_BIT 5
`define LCRG_IDLE_MUTE_BIT   4
`define LCRG_DET_MODE_HI     3
`define LCRG_DET_MODE_LO     2
`define LCRG_SHORT_PROT_BIT  7
`define LCRG_GEN12_BIT       6
`define LCRG_SWING_HI        2
`define LCRG_SWING_LO        0
`define LCRG_STATUS_DET_BIT  7

// ==========================================================
// receiver-detect codes
`define LCRG_DET_HIGHZ      2'h0
`define LCRG_DET_LIMITED    2'h1
`define LCRG_DET_ENDLESS    2'h2
`define LCRG_DET_FIXED50    2'h3

// ==========================================================
// timing
`define LCRG_CLK_KHZ         250000
`define LCRG_DET_PERIOD_MS   12
`define LCRG_DET_WINDOW_MS   600
`define LCRG_DET_PERIOD_CYC  (`LCRG_DET_PERIOD_MS * `LCRG_CLK_KHZ)
`define LCRG_DET_ATTEMPTS    (`LCRG_DET_WINDOW_MS / `LCRG_DET_PERIOD_MS)

`endif

// ---- rtl/lcrg_pkg.sv ----
/*
  types shared by the lane configuration register group.
  assumes nothing beyond a SystemVerilog compiler.
*/
package lcrg_pkg;

  // ==========================================================
  // receiver-detect sequencer states
  typedef enum logic [1:0] {
    LCRG_DET_OFF,       // no search running
    LCRG_DET_SEARCH,    // periodic probing
    LCRG_DET_FOUND,     // receiver seen, 50 ohm applied
    LCRG_DET_EXPIRED    // limited search ran out
  } lcrg_det_state_t;

endpackage

// ---- rtl/lcrg_detect_timer.sv ----
/*
  periodic probe timer for receiver detection: one attempt pulse per
  period while run is high, and an attempt count limit.
  assumes run drops for at least one cycle to restart the schedule.
*/
`timescale 1ns/1ns
`include "lcrg_map.svh"

module lcrg_detect_timer #(
  parameter int PERIOD_CYCLES = `LCRG_DET_PERIOD_CYC,  // cycles per probe
  parameter int ATTEMPTS      = `LCRG_DET_ATTEMPTS     // probes in a limited search
) (
  input  wire logic clock,      // core clock
  input  wire logic resetn,     // async reset, active low
  input  wire logic run,        // search in progress
  input  wire logic limited,    // stop after ATTEMPTS probes
  output logic      attempt,    // one-cycle probe pulse
  output logic      exhausted   // limited search used all probes
);

  localparam int CW = $clog2(PERIOD_CYCLES + 1);
  localparam int AW = $clog2(ATTEMPTS + 1);
  localparam logic [CW-1:0] LAST_CYC = CW'(PERIOD_CYCLES - 1);
  localparam logic [AW-1:0] MAX_ATT  = AW'(ATTEMPTS);

  logic [CW-1:0] cyc_reg;       // cycles into the current period
  logic [CW-1:0] cyc_next;
  logic [AW-1:0] att_reg;       // probes issued so far
  logic [AW-1:0] att_next;
  logic          attempt_reg;   // registered probe pulse
  wire           period_end;    // last cycle of a period
  wire           at_limit;      // probe budget spent

  assign at_limit   = limited && (att_reg >= MAX_ATT);
  assign period_end = run && !at_limit && (cyc_reg == LAST_CYC);
  assign cyc_next   = (!run || period_end) ? '0 : cyc_reg + 1'b1;
  assign att_next   = !run ? '0 : (period_end ? att_reg + 1'b1 : att_reg);

  // ==========================================================
  // counters, cleared whenever the search stops
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cyc_reg     <= '0;
      att_reg     <= '0;
      attempt_reg <= 1'b0;
    end
    else
    begin
      cyc_reg     <= cyc_next;
      att_reg     <= att_next;
      attempt_reg <= period_end;
    end
  end

  assign attempt   = attempt_reg;
  assign exhausted = run && at_limit;

endmodule // lcrg_detect_timer

// ---- rtl/lcrg_lane_regs.sv ----
/*
  per-lane configuration register group: idle/detect, equalizer and
  swing registers, the receiver-detect status bit, and the lane controls
  derived from them, including the periodic receiver-detect sequencer.
  assumes the slave register port is driven by serial slave logic on the
  same clock: one-cycle write and read strobes with a stable address.
*/
`timescale 1ns/1ns
`include "lcrg_map.svh"

module lcrg_lane_regs #(
  parameter int DETECT_PERIOD_CYCLES = `LCRG_DET_PERIOD_CYC,  // cycles per probe
  parameter int DETECT_ATTEMPTS      = `LCRG_DET_ATTEMPTS     // probes in limited mode
) (
  input  wire logic       clock,           // core clock, 250 MHz
  input  wire logic       resetn,          // async reset, active low
  input  wire logic [7:0] reg_addr,        // register offset
  input  wire logic [7:0] reg_wdata,       // write data
  input  wire logic       reg_wr,          // write strobe, one cycle
  input  wire logic       reg_rd,          // read strobe, one cycle
  output logic      [7:0] reg_rdata,       // read data, registered
  output logic            reg_hit,         // last read hit a mapped offset
  input  wire logic       auto_idle,       // idle detector says input idle
  input  wire logic       rx_sense,        // receiver present, valid with probe
  output logic            detect_attempt,  // one-cycle probe request
  output logic            output_mute,     // lane output in electrical idle
  output logic            term_50ohm,      // input termination 50 ohm, else high-z
  output logic      [7:0] input_equalizer, // equalizer level
  output logic            short_protect_en,// short-circuit protection on
  output logic            gen12_mode,      // 1 gen1/gen2, 0 gen3
  output logic      [2:0] output_swing,    // amplitude code
  output logic            receiver_detect_status // receiver found
);

  // ==========================================================
  // address decode
  wire hit_idle;     // idle/detect register selected
  wire hit_eq;       // equalizer register selected
  wire hit_swing;    // swing register selected
  wire hit_status;   // status register selected
  wire wr_idle;      // write to idle/detect
  wire wr_eq;        // write to equalizer
  wire wr_swing;     // write to swing

  assign hit_idle   = (reg_addr == `LCRG_ADDR_IDLE);
  assign hit_eq     = (reg_addr == `LCRG_ADDR_EQ);
  assign hit_swing  = (reg_addr == `LCRG_ADDR_SWING);
  assign hit_status = (reg_addr == `LCRG_ADDR_STATUS);
  assign wr_idle    = reg_wr && hit_idle;
  assign wr_eq      = reg_wr && hit_eq;
  assign wr_swing   = reg_wr && hit_swing;

  // ==========================================================
  // register storage
  logic [7:0] idle_reg;     // idle and detect controls
  logic [7:0] idle_next;
  logic [7:0] eq_reg;       // equalizer setting
  logic [7:0] eq_next;
  logic [7:0] swing_reg;    // protection, rate mode, amplitude
  logic [7:0] swing_next;

  // whole byte kept, reserved bits included
  assign idle_next  = wr_idle  ? reg_wdata : idle_reg;
  assign eq_next    = wr_eq    ? reg_wdata : eq_reg;
  // reserved 5:3 stored as written; host supplies 101
  assign swing_next = wr_swing ? reg_wdata : swing_reg;

  // register file, loaded by the write strobe
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      idle_reg  <= `LCRG_RST_IDLE;
      eq_reg    <= `LCRG_RST_EQ;
      swing_reg <= `LCRG_RST_SWING;
    end
    else
    begin
      idle_reg  <= idle_next;
      eq_reg    <= eq_next;
      swing_reg <= swing_next;
    end
  end

  // ==========================================================
  // field extraction
  wire       idle_manual;   // manual idle control selected
  wire       idle_force;    // manual mute request
  wire [1:0] det_mode;      // receiver-detect code
  wire       det_search;    // a probing code is selected
  wire       det_limited;   // probing stops after the window

  assign idle_manual = idle_reg[`LCRG_IDLE_MANUAL_BIT];
  assign idle_force  = idle_reg[`LCRG_IDLE_MUTE_BIT];
  // pin level is never consulted: register code alone decides
  assign det_mode    = idle_reg[`LCRG_DET_MODE_HI:`LCRG_DET_MODE_LO];
  assign det_search  = (det_mode == `LCRG_DET_LIMITED) || (det_mode == `LCRG_DET_ENDLESS);
  assign det_limited = (det_mode == `LCRG_DET_LIMITED);

  // a write to the idle register restarts any search
  wire det_restart;          // idle/detect register rewritten
  assign det_restart = wr_idle;

  // ==========================================================
  // probe timer
  wire timer_run;            // timer counts only while searching
  wire probe;                // probe pulse from the timer
  wire probe_spent;          // limited search exhausted
  lcrg_pkg::lcrg_det_state_t det_state_reg;   // sequencer state
  lcrg_pkg::lcrg_det_state_t det_state_next;
  wire in_search;            // sequencer is probing

  // a rewrite clears the timer, but a probe already issued still counts
  assign in_search = (det_state_reg == lcrg_pkg::LCRG_DET_SEARCH);
  assign timer_run = in_search && !det_restart;

  lcrg_detect_timer #(
    .PERIOD_CYCLES (DETECT_PERIOD_CYCLES),
    .ATTEMPTS      (DETECT_ATTEMPTS)
  ) u_timer (
    .clock     (clock),
    .resetn    (resetn),
    .run       (timer_run),
    .limited   (det_limited),
    .attempt   (probe),
    .exhausted (probe_spent)
  );

  wire found_now;            // probe saw a receiver
  assign found_now = probe && rx_sense && in_search;

  // ==========================================================
  // receiver-detect sequencer
  always_comb
  begin
    det_state_next = det_state_reg;
    case (det_state_reg)
      lcrg_pkg::LCRG_DET_OFF:
      begin
        // a probing code starts a fresh search
        if (det_search)
          det_state_next = lcrg_pkg::LCRG_DET_SEARCH;
      end
      lcrg_pkg::LCRG_DET_SEARCH:
      begin
        // a hit in the same cycle as a rewrite is kept
        if (found_now)
          det_state_next = lcrg_pkg::LCRG_DET_FOUND;
        else if (!det_search)
          det_state_next = lcrg_pkg::LCRG_DET_OFF;
        else if (probe_spent && !det_restart)
          det_state_next = lcrg_pkg::LCRG_DET_EXPIRED;
      end
      lcrg_pkg::LCRG_DET_FOUND:
      begin
        // rewriting the mode starts over
        if (!det_search)
          det_state_next = lcrg_pkg::LCRG_DET_OFF;
        else if (det_restart)
          det_state_next = lcrg_pkg::LCRG_DET_SEARCH;
      end
      lcrg_pkg::LCRG_DET_EXPIRED:
      begin
        // stays silent until the mode is rewritten
        if (!det_search)
          det_state_next = lcrg_pkg::LCRG_DET_OFF;
        else if (det_restart)
          det_state_next = lcrg_pkg::LCRG_DET_SEARCH;
      end
      default:
      begin
        det_state_next = lcrg_pkg::LCRG_DET_OFF;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      det_state_reg <= lcrg_pkg::LCRG_DET_OFF;
    else
      det_state_reg <= det_state_next;
  end

  // ==========================================================
  // lane controls
  wire mute_next;            // next output idle state
  wire term_next;            // next termination choice
  wire det_found;            // sequencer holds a detection

  // manual bit 4 or the idle detector, never the idle pin
  assign mute_next = idle_manual ? idle_force : auto_idle;
  assign det_found = (det_state_reg == lcrg_pkg::LCRG_DET_FOUND);
  // fixed 50 ohm code 11, or 50 ohm once a search has found the receiver
  assign term_next = (det_mode == `LCRG_DET_FIXED50) ||
                     (det_search && det_found);

  logic mute_reg;            // registered mute
  logic term_reg;            // registered termination

  // output flops for the mute and termination controls
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      mute_reg <= 1'b0;
      term_reg <= 1'b0;
    end
    else
    begin
      mute_reg <= mute_next;
      term_reg <= term_next;
    end
  end

  assign output_mute      = mute_reg;
  assign term_50ohm       = term_reg;
  assign detect_attempt   = probe && in_search;
  assign input_equalizer  = eq_reg;
  assign short_protect_en = swing_reg[`LCRG_SHORT_PROT_BIT];
  assign gen12_mode       = swing_reg[`LCRG_GEN12_BIT];
  assign output_swing     = swing_reg[`LCRG_SWING_HI:`LCRG_SWING_LO];
  assign receiver_detect_status = det_found;

  // ==========================================================
  // read path
  logic [7:0] rd_mux;        // selected read value
  logic       rd_hit;        // offset is mapped

  // address select, unmapped offsets read zero
  always_comb
  begin
    rd_mux = 8'h00;
    rd_hit = 1'b1;
    if (hit_idle)
      rd_mux = idle_reg;
    else if (hit_eq)
      rd_mux = eq_reg;
    else if (hit_swing)
      rd_mux = swing_reg;
    else if (hit_status)
      rd_mux[`LCRG_STATUS_DET_BIT] = det_found;
    else
      rd_hit = 1'b0;
  end

  logic [7:0] rdata_reg;     // held read data
  logic       hit_reg;       // held hit flag

  // read data captured on the read strobe and held
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_reg <= 8'h00;
      hit_reg   <= 1'b0;
    end
    else if (reg_rd)
    begin
      rdata_reg <= rd_mux;
      hit_reg   <= rd_hit;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_hit   = hit_reg;

endmodule // lcrg_lane_regs

// ---- verif/lcrg_host_model.sv ----
/*
  serial host model driving the slave register port of one lane.
  assumes the bench clock; every change is made on a falling edge.
*/
`timescale 1ns/1ns
module lcrg_host_model (
  input  wire logic       clock,     // core clock
  output logic      [7:0] reg_addr,  // offset
  output logic      [7:0] reg_wdata, // write data
  output logic            reg_wr,    // write strobe
  output logic            reg_rd,    // read strobe
  input  wire logic [7:0] reg_rdata  // read data
);
  // ==========================================================
  // bus cycles
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;

  // one-cycle write, reserved fields forced to their required values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = (a == 8'h42) ? {d[7:6], 3'h5, d[2:0]} :
                (a == 8'h40) ? {2'h0, d[5:2], 2'h0} : d;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr    = 1'b0;
  endtask

  // one-cycle read, data taken after the answering edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clock);
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask
endmodule // lcrg_host_model

// ---- verif/lcrg_lane_regs_checker.sv ----
/*
  port assertions for the lane register group.
  assumes it is bound into lcrg_lane_regs and sees only its ports.
*/
`timescale 1ns/1ns
module lcrg_lane_regs_checker #(
  parameter int DETECT_PERIOD_CYCLES = 3000000, // cycles per probe
  parameter int DETECT_ATTEMPTS      = 50       // limited probes
) (
  input wire logic       clock,                 // clock
  input wire logic       resetn,                // reset
  input wire logic [7:0] reg_addr,              // offset
  input wire logic [7:0] reg_wdata,             // data in
  input wire logic       reg_wr,                // write
  input wire logic       reg_rd,                // read
  input wire logic [7:0] reg_rdata,             // data out
  input wire logic       reg_hit,               // mapped
  input wire logic       auto_idle,             // idle level
  input wire logic       rx_sense,              // sink seen
  input wire logic       detect_attempt,        // probe
  input wire logic       output_mute,           // mute
  input wire logic       term_50ohm,            // 50 ohm
  input wire logic [7:0] input_equalizer,       // eq level
  input wire logic       short_protect_en,      // protect
  input wire logic       gen12_mode,            // rate
  input wire logic [2:0] output_swing,          // swing
  input wire logic       receiver_detect_status // found
);
  // ==========================================================
  // shadow registers and probe counters
  logic [7:0] sh [3];   // writable registers
  int         att_cnt;  // probes since restart
  int         gap;      // cycles since last probe
  logic       seen;     // probe since restart
  wire        wr_idle = reg_wr && reg_addr == 8'h40;
  wire        mapped  = reg_addr[7:2] == 6'h10;
  wire  [1:0] det     = sh[0][3:2];
  wire  [7:0] rd_map  = (reg_addr == 8'h43) ? {receiver_detect_status, 7'h00} : sh[reg_addr[1:0]];

  // follow bus writes; a write to 0x40 restarts the probe schedule
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sh      <= '{8'h00, 8'h2f, 8'had};
      att_cnt <= 0;
      gap     <= 0;
      seen    <= 1'b0;
    end
    else
    begin
      if (reg_wr && mapped && reg_addr != 8'h43)
        sh[reg_addr[1:0]] <= reg_wdata;
      att_cnt <= wr_idle ? 0 : att_cnt + int'(detect_attempt);
      gap     <= (wr_idle || detect_attempt) ? 1 : gap + 1;
      seen    <= wr_idle ? 1'b0 : (seen || detect_attempt);
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_MUTE_MANUAL: assert property ($past(resetn) && $past(sh[0][5]) |-> output_mute == $past(sh[0][4]))
    else $error("manual mute does not follow its bit");
  AST_MUTE_AUTO: assert property ($past(resetn) && !$past(sh[0][5]) |-> output_mute == $past(auto_idle))
    else $error("automatic mute does not follow idle input");
  AST_EQ: assert property (input_equalizer == sh[1])
    else $error("equalizer output differs from written value");
  AST_SWING: assert property ({short_protect_en, gen12_mode, output_swing} == {sh[2][7:6], sh[2][2:0]})
    else $error("swing register fields wrong at outputs");
  AST_TERM_FIXED: assert property ($past(resetn) && $past(det) == 2'h3 |-> term_50ohm)
    else $error("fixed termination not applied");
  AST_TERM_HIGHZ: assert property ($past(det) == 2'h0 && det == 2'h0 |-> !term_50ohm && !detect_attempt)
    else $error("high impedance mode terminates or probes");
  AST_FOUND: assert property (detect_attempt && rx_sense |=> receiver_detect_status
                              ##1 (term_50ohm == ($past(det) != 2'h0)))
    else $error("found receiver not reported then terminated");
  AST_SEARCH_HIGHZ: assert property ($past(det) inside {2'h1, 2'h2} && det inside {2'h1, 2'h2}
                                     && !$past(receiver_detect_status) |-> !term_50ohm)
    else $error("termination applied before detection");
  AST_LIMIT: assert property (det == 2'h1 && att_cnt >= DETECT_ATTEMPTS |-> !detect_attempt)
    else $error("limited search probes too often");
  AST_PERIOD: assert property (detect_attempt && seen |-> gap == DETECT_PERIOD_CYCLES)
    else $error("probe spacing wrong");
  AST_RD_MAPPED: assert property (reg_rd && mapped |=> reg_hit && reg_rdata == $past(rd_map))
    else $error("mapped read returns wrong data");
  AST_RD_UNMAPPED: assert property (reg_rd && !mapped |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read not refused");
endmodule // lcrg_lane_regs_checker

bind lcrg_lane_regs lcrg_lane_regs_checker #(
  .DETECT_PERIOD_CYCLES(DETECT_PERIOD_CYCLES), .DETECT_ATTEMPTS(DETECT_ATTEMPTS)) lane_chk (
  .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .auto_idle(auto_idle), .rx_sense(rx_sense),
  .detect_attempt(detect_attempt), .output_mute(output_mute), .term_50ohm(term_50ohm),
  .input_equalizer(input_equalizer), .short_protect_en(short_protect_en), .gen12_mode(gen12_mode),
  .output_swing(output_swing), .receiver_detect_status(receiver_detect_status));

// ---- verif/test_lane_config_register_group.sv ----
/*
  self-checking bench for the lane register group with a host model.
  assumes rtl/ on the include path and the bound checker alongside.
*/
`timescale 1ns/1ns
module test_lane_config_register_group;
  localparam int PER = 4; // short probe period
  localparam int ATT = 3; // short limited search
  logic       clock = 1'b0, resetn = 1'b0, auto_idle = 1'b0, rx_sense = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, input_equalizer, v;
  logic       reg_wr, reg_rd, reg_hit, detect_attempt, output_mute, term_50ohm;
  logic       short_protect_en, gen12_mode, receiver_detect_status;
  logic [2:0] output_swing;
  int         error_cnt = 0, n_checks = 0, att = 0, seed = 32'hfd04;
  int         mdl[int]; // expected contents by offset
  logic [7:0] idl[5] = '{8'h30, 8'h2c, 8'h10, 8'h0c, 8'h00};

  lcrg_lane_regs #(
    .DETECT_PERIOD_CYCLES (PER),
    .DETECT_ATTEMPTS      (ATT)
  ) uut (
    .clock                  (clock),
    .resetn                 (resetn),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .reg_hit                (reg_hit),
    .auto_idle              (auto_idle),
    .rx_sense               (rx_sense),
    .detect_attempt         (detect_attempt),
    .output_mute            (output_mute),
    .term_50ohm             (term_50ohm),
    .input_equalizer        (input_equalizer),
    .short_protect_en       (short_protect_en),
    .gen12_mode             (gen12_mode),
    .output_swing           (output_swing),
    .receiver_detect_status (receiver_detect_status)
  );
  lcrg_host_model host (
    .clock     (clock),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  always #2 clock = ~clock;
  // count probes
  always @(posedge clock)
    if (detect_attempt === 1'b1)
      att <= att + 1;

  // ==========================================================
  // compare, write, read and port tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (mdl.exists(a) && a != 8'h43)
      mdl[a] = d;
  endtask
  task automatic get(input logic [7:0] a);
    host.rd(a, v);
    chk(v, mdl.exists(a) ? 8'(mdl[a]) : 8'h00, "rdata");
    chk({7'h0, reg_hit}, {7'h0, 1'(mdl.exists(a))}, "hit");
  endtask
  task automatic outs();
    logic [7:0] m;
    m = 8'(mdl[64]);
    repeat (2) @(negedge clock);
    chk(input_equalizer, 8'(mdl[65]), "eq");
    chk({short_protect_en, gen12_mode, 3'h5, output_swing}, 8'(mdl[66]), "swing");
    chk({5'h0, receiver_detect_status, term_50ohm, output_mute},
        {5'h0, mdl[67] != 0, m[3:2] == 2'h3 || mdl[67] != 0, m[5] ? m[4] : auto_idle}, "lane");
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial
  begin
    mdl[64] = 8'h00;
    mdl[65] = 8'h2f;
    mdl[66] = 8'had;
    mdl[67] = 8'h00;
    repeat (4) @(posedge clock);
    @(negedge clock) resetn = 1'b1;
    outs();
    for (int a = 64; a < 69; a++)
      get(8'(a));
    $display("test reset done");
    // every swing code and rate bit, random equalizer and idle level
    for (int i = 0; i < 8; i++)
    begin
      auto_idle = 1'($random(seed));
      put(8'h41, 8'($random(seed)));
      put(8'h42, {i[1:0], 3'h5, i[2:0]});
      outs();
      get(8'h42);
    end
    get(8'h41);
    put(8'h43, 8'hff);
    put(8'h44, 8'hff);
    get(8'h43);
    get(8'h44);
    $display("test registers done");
    // idle handling and fixed termination modes
    for (int k = 0; k < 5; k++)
    begin
      auto_idle = k[0];
      put(8'h40, idl[k]);
      outs();
    end
    $display("test idle done");
    // limited search runs out, endless search finds a receiver
    att = 0;
    put(8'h40, 8'h04);
    repeat (7 * PER) @(negedge clock);
    chk(8'(att), 8'(ATT), "limited probes");
    outs();
    att = 0;
    put(8'h40, 8'h08);
    repeat ((ATT + 3) * PER) @(negedge clock);
    chk(8'(att > ATT), 8'h01, "endless probes");
    rx_sense = 1'b1;
    repeat (PER + 2) @(negedge clock);
    mdl[67] = 8'h80;
    outs();
    get(8'h43);
    rx_sense = 1'b0;
    mdl[67] = 8'h00;
    put(8'h40, 8'h00);
    outs();
    get(8'h43);
    $display("test detect done");
    stop_test();
  end

  // hang guard
  initial
  begin
    #(4 * 5000);
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
endmodule // test_lane_config_register_group
